// ==== rtl/cal_ctrl_pkg.sv ====
// Package for the calibration control register bank.
// Assumes one 100 MHz system clock and a byte-wide register access port.
package cal_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] offset_averaging_config_addr          = 8'h68;
  localparam logic [7:0] calibration_progress_flags_addr       = 8'h6a;
  localparam logic [7:0] calibration_pin_setup_addr            = 8'h6b;
  localparam logic [7:0] software_calibration_trigger_addr     = 8'h6c;
  localparam logic [7:0] low_power_background_calibration_addr = 8'h6e;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] offset_averaging_config_rst          = 8'h61;
  localparam logic [7:0] calibration_pin_setup_rst            = 8'h00;
  localparam logic [7:0] software_calibration_trigger_rst     = 8'h01;
  localparam logic [7:0] low_power_background_calibration_rst = 8'h88;
  localparam logic [3:0] averaging_low_nibble                 = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int avg_depth_lsb   = 4;
  localparam int status_code_lsb = 2;
  localparam int stopped_bit     = 1;
  localparam int fg_complete_bit = 0;
  localparam int status_sel_lsb  = 1;
  localparam int trig_src_bit    = 0;
  localparam int soft_trig_bit   = 0;
  localparam int sleep_code_lsb  = 5;
  localparam int wake_code_lsb   = 3;
  localparam int wake_mode_bit   = 1;
  localparam int lp_enable_bit   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Low-power timing: delay = (2^exp + 1) * unit clock cycles.
  localparam int                    lp_unit_cycles = 256;
  localparam logic [7:0][5:0] sleep_exp = {6'h21, 6'h1e, 6'h1b, 6'h15,
                                           6'h15, 6'h12, 6'h0f, 6'h03};
  localparam logic [3:0][5:0] wake_exp  = {6'h18, 6'h15, 6'h12, 6'h03};

  ////////////////////////////////////////////////////////////////////////////
  // Status pin selections and sequencer states.
  localparam logic [1:0] sel_fg_complete = 2'h0;
  localparam logic [1:0] sel_stopped     = 2'h1;
  localparam logic [1:0] sel_alarm       = 2'h2;

  typedef enum logic [2:0] {
    st_idle     = 3'b000,
    st_clear    = 3'b001,
    st_fg_run   = 3'b010,
    st_done     = 3'b011,
    st_bg_run   = 3'b100,
    st_lp_sleep = 3'b101,
    st_lp_wake  = 3'b110
  } cal_state_type;

  // One register access from the serial control interface.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Feedback from the calibration engine.
  typedef struct packed {
    logic       foreground_complete_flag;
    logic       bg_stopped;
    logic       bg_pass_done;
    logic       alarm;
    logic [2:0] code;
  } engine_stat_type;

endpackage

// ==== rtl/pin_level_sync.sv ====
// Three-stage synchroniser for an asynchronous pin level.
// Assumes the pin may change at any time relative to clk_sys.
`timescale 1ns/1ps
module pin_level_sync (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Pin and clean level.
  input  wire logic pin_async,
  output logic      level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The level moves only once the second and third stages agree.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule

// ==== rtl/cal_ctrl_regs.sv ====
// Calibration control register bank with restart and low-power sequencer.
// Assumes a serial interface front end presents one-cycle byte accesses and
// an external calibration engine answers with done and stopped indications.
`timescale 1ns/1ps
// Contract
// - A restart clears stored values, then runs foreground calibration if selected, else skips it.
// - Bits 6-4 of the averaging register set the offset averaging depth, default 6.
// - The status register is read-only with code in bits 4-2 and flags in bits 1-0.
// - The stopped flag reads 1 once background calibration halts and 0 when it resumes.
// - With background calibration off, stopped is set when foreground finishes or is skipped.
// - The foreground complete flag is set when foreground finishes or is skipped.
// - A 2-bit select in bits 2-1 drives the status pin: complete, stopped, alarm, low.
// - With trigger source 0 the software trigger bit is used and the pin is ignored.
// - With trigger source 1 the hardware trigger pin is used and the software bit ignored.
// - The software trigger bit, reset 1, acts exactly as the hardware pin would.
// - The low-power register resets to 0x88 with sleep, wake, reserved, mode and enable fields.
// - In trigger mode a sleeping converter wakes when the trigger is low, else after the delay.
// - Low-power operation acts only while background calibration is enabled.
module cal_ctrl_regs #(
  parameter int lp_unit = cal_ctrl_pkg::lp_unit_cycles
) (
  // Clock and reset.
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  // Register access from the serial control interface.
  input  wire cal_ctrl_pkg::reg_req_type     reg_req,
  output logic [7:0]                         reg_rdata_q,
  // Calibration configuration levels.
  input  wire logic                          cal_enable,
  input  wire logic                          foreground_run_select,
  input  wire logic                          background_recal_enable,
  // Pins.
  input  wire logic                          hardware_trigger_pin,
  output logic                               calibration_status_pin_q,
  // Calibration engine.
  input  wire cal_ctrl_pkg::engine_stat_type engine,
  output logic                               clear_values_q,
  output logic                               fg_start_q,
  output logic                               bg_run_q,
  output logic                               adc_sleep_q,
  output logic                               cal_trigger_q,
  output logic [2:0]                         offset_averaging_depth_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [7:0] avg_q, pin_q, soft_q, lp_q;
  logic       fg_complete_q, stopped_q, cal_en_q;
  logic [2:0] code_q;
  logic [47:0] cnt_q, cnt_d;
  logic       hw_level;
  cal_ctrl_pkg::cal_state_type state_q, state_d;

  // Delay in cycles for a power-of-two exponent.
  function automatic logic [47:0] lp_cycles(input logic [5:0] e);
    lp_cycles = ((48'h1 << e) + 48'h1) * 48'(lp_unit);
  endfunction

  pin_level_sync trig_sync (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .pin_async (hardware_trigger_pin),
    .level_q   (hw_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Field decode and sequencer events.
  wire        hit_avg   = reg_req.addr == cal_ctrl_pkg::offset_averaging_config_addr;
  wire        hit_stat  = reg_req.addr == cal_ctrl_pkg::calibration_progress_flags_addr;
  wire        hit_pin   = reg_req.addr == cal_ctrl_pkg::calibration_pin_setup_addr;
  wire        hit_soft  = reg_req.addr == cal_ctrl_pkg::software_calibration_trigger_addr;
  wire        hit_lp    = reg_req.addr == cal_ctrl_pkg::low_power_background_calibration_addr;
  wire [1:0]  pin_sel   = pin_q[cal_ctrl_pkg::status_sel_lsb +: 2];
  wire        trig_src  = pin_q[cal_ctrl_pkg::trig_src_bit];
  wire        soft_bit  = soft_q[cal_ctrl_pkg::soft_trig_bit];
  wire [2:0]  sleep_cd  = lp_q[cal_ctrl_pkg::sleep_code_lsb +: 3];
  wire [1:0]  wake_cd   = lp_q[cal_ctrl_pkg::wake_code_lsb +: 2];
  wire        wake_mode = lp_q[cal_ctrl_pkg::wake_mode_bit];
  wire        lp_active = lp_q[cal_ctrl_pkg::lp_enable_bit] & background_recal_enable;
  wire        restart   = cal_enable & ~cal_en_q;
  wire        fg_skip   = (state_q == cal_ctrl_pkg::st_clear) & ~foreground_run_select;
  wire        fg_finish = (state_q == cal_ctrl_pkg::st_fg_run) & engine.foreground_complete_flag;
  wire        fg_event  = fg_skip | fg_finish;
  wire        trig_sel  = trig_src ? hw_level : soft_bit;
  wire        status_mux = (pin_sel == cal_ctrl_pkg::sel_fg_complete) ? fg_complete_q :
                           (pin_sel == cal_ctrl_pkg::sel_stopped)     ? stopped_q :
                           (pin_sel == cal_ctrl_pkg::sel_alarm)       ? engine.alarm :
                           1'b0;
  wire [7:0]  stat_word = {3'h0, code_q, stopped_q, fg_complete_q};
  wire [7:0]  rd_word   = hit_avg  ? {avg_q[7:4], cal_ctrl_pkg::averaging_low_nibble} :
                          hit_stat ? stat_word :
                          hit_pin  ? pin_q :
                          hit_soft ? soft_q :
                          hit_lp   ? lp_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state: restart, foreground, background and low-power sleep.
  always_comb begin
    state_d = state_q;
    cnt_d   = (cnt_q != 48'h0) ? cnt_q - 48'h1 : cnt_q;
    case (state_q)
      cal_ctrl_pkg::st_idle: begin
        if (restart) begin
          state_d = cal_ctrl_pkg::st_clear;
        end
      end
      cal_ctrl_pkg::st_clear: begin
        if (foreground_run_select) begin
          state_d = cal_ctrl_pkg::st_fg_run;
        end else begin
          state_d = background_recal_enable ? cal_ctrl_pkg::st_bg_run : cal_ctrl_pkg::st_done;
        end
      end
      cal_ctrl_pkg::st_fg_run: begin
        if (engine.foreground_complete_flag) begin
          state_d = background_recal_enable ? cal_ctrl_pkg::st_bg_run : cal_ctrl_pkg::st_done;
        end
      end
      cal_ctrl_pkg::st_bg_run: begin
        if (lp_active && engine.bg_pass_done) begin
          state_d = cal_ctrl_pkg::st_lp_sleep;
          cnt_d   = lp_cycles(cal_ctrl_pkg::sleep_exp[sleep_cd]);
        end
      end
      cal_ctrl_pkg::st_lp_sleep: begin
        if (!lp_active) begin
          state_d = cal_ctrl_pkg::st_bg_run;
        end else if (wake_mode ? !cal_trigger_q : (cnt_q <= 48'h1)) begin
          state_d = cal_ctrl_pkg::st_lp_wake;
          cnt_d   = lp_cycles(cal_ctrl_pkg::wake_exp[wake_cd]);
        end
      end
      cal_ctrl_pkg::st_lp_wake: begin
        if (cnt_q <= 48'h1) begin
          state_d = cal_ctrl_pkg::st_bg_run;
        end
      end
      default: begin
        state_d = cal_ctrl_pkg::st_idle;
      end
    endcase
    if (!cal_enable) begin
      state_d = cal_ctrl_pkg::st_idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers and engine controls.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q        <= cal_ctrl_pkg::st_idle;
      cnt_q          <= 48'h0;
      cal_en_q       <= 1'b0;
      clear_values_q <= 1'b0;
      fg_start_q     <= 1'b0;
      bg_run_q       <= 1'b0;
      adc_sleep_q    <= 1'b0;
    end else begin
      state_q        <= state_d;
      cnt_q          <= cnt_d;
      cal_en_q       <= cal_enable;
      clear_values_q <= state_d == cal_ctrl_pkg::st_clear;
      fg_start_q     <= (state_q == cal_ctrl_pkg::st_clear) & foreground_run_select;
      bg_run_q       <= state_d == cal_ctrl_pkg::st_bg_run;
      adc_sleep_q    <= state_d == cal_ctrl_pkg::st_lp_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a completion event wins over the restart clear.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fg_complete_q <= 1'b0;
      stopped_q     <= 1'b0;
      code_q        <= 3'h0;
    end else begin
      code_q <= engine.code;
      if (fg_event) begin
        fg_complete_q <= 1'b1;
      end else if (state_d == cal_ctrl_pkg::st_clear) begin
        fg_complete_q <= 1'b0;
      end
      if (fg_event && !background_recal_enable) begin
        stopped_q <= 1'b1;
      end else if (background_recal_enable && state_q == cal_ctrl_pkg::st_bg_run) begin
        stopped_q <= engine.bg_stopped;
      end else if (state_d == cal_ctrl_pkg::st_clear) begin
        stopped_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, read data, trigger and status pin.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avg_q                    <= cal_ctrl_pkg::offset_averaging_config_rst;
      pin_q                    <= cal_ctrl_pkg::calibration_pin_setup_rst;
      soft_q                   <= cal_ctrl_pkg::software_calibration_trigger_rst;
      lp_q                     <= cal_ctrl_pkg::low_power_background_calibration_rst;
      reg_rdata_q              <= 8'h00;
      cal_trigger_q            <= 1'b0;
      calibration_status_pin_q <= 1'b0;
      offset_averaging_depth_q <=
        cal_ctrl_pkg::offset_averaging_config_rst[cal_ctrl_pkg::avg_depth_lsb +: 3];
    end else begin
      if (reg_req.wr && hit_avg) avg_q <= reg_req.wdata;
      if (reg_req.wr && hit_pin) pin_q <= reg_req.wdata;
      if (reg_req.wr && hit_soft) soft_q <= reg_req.wdata;
      if (reg_req.wr && hit_lp) lp_q <= reg_req.wdata;
      if (reg_req.rd) reg_rdata_q <= rd_word;
      cal_trigger_q            <= trig_sel;
      calibration_status_pin_q <= status_mux;
      offset_averaging_depth_q <= avg_q[cal_ctrl_pkg::avg_depth_lsb +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_restart_clear_pulse: assert property (restart && cal_enable
      |=> clear_values_q ##1 !clear_values_q)
    else $error("restart did not give one clear pulse");
  a_skip_sets_done: assert property (fg_skip |=> fg_complete_q && !fg_start_q)
    else $error("skipped foreground not flagged complete");
  a_stop_without_bg: assert property (fg_event && !background_recal_enable |=> stopped_q)
    else $error("stopped flag missing without background");
  a_stop_follows_bg: assert property (background_recal_enable && state_q == cal_ctrl_pkg::st_bg_run
      && !fg_event |=> stopped_q == $past(engine.bg_stopped))
    else $error("stopped flag not following background halt");
  a_pin_low_select: assert property (pin_sel == 2'h3 |=> !calibration_status_pin_q)
    else $error("status pin not low for select 3");
  a_pin_done_select: assert property (pin_sel == cal_ctrl_pkg::sel_fg_complete
      |=> calibration_status_pin_q == $past(fg_complete_q))
    else $error("status pin not showing complete flag");
  a_soft_trigger: assert property (!trig_src |=> cal_trigger_q == $past(soft_bit))
    else $error("software trigger not selected");
  a_hard_trigger: assert property (trig_src |=> cal_trigger_q == $past(hw_level))
    else $error("hardware trigger not selected");
  a_lp_needs_bg: assert property (!background_recal_enable [*2] |-> !adc_sleep_q)
    else $error("sleep without background calibration");
  a_wake_on_trig: assert property (state_q == cal_ctrl_pkg::st_lp_sleep && wake_mode && lp_active
      && cal_enable && !cal_trigger_q |=> state_q == cal_ctrl_pkg::st_lp_wake)
    else $error("trigger low did not wake converter");

endmodule

// ==== tb/cal_engine_model.sv ====
// Behavioural calibration engine that faces the register bank's engine port.
// Assumes the bench changes its control inputs just after a falling clock edge.
`timescale 1ns/1ps
module cal_engine_model #(
  parameter int fg_latency = 8
) (
  // Clock and reset.
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  // Requests from the register bank.
  input  wire logic                     fg_start_q,
  input  wire logic                     bg_run_q,
  // Bench controls.
  input  wire logic                     stop_req,
  input  wire logic                     pass_req,
  input  wire logic                     alarm_in,
  input  wire logic [2:0]               code_in,
  // Engine feedback.
  output cal_ctrl_pkg::engine_stat_type engine
);
  int   fg_cnt_q;
  logic foreground_complete_flag_q;
  logic pass_done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Foreground finishes a fixed time after its start; a pass ends only while running.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fg_cnt_q    <= 0;
      foreground_complete_flag_q   <= 1'b0;
      pass_done_q <= 1'b0;
    end else begin
      foreground_complete_flag_q   <= (fg_cnt_q == 1);
      pass_done_q <= pass_req & bg_run_q;
      if (fg_start_q) begin
        fg_cnt_q <= fg_latency;
      end else if (fg_cnt_q != 0) begin
        fg_cnt_q <= fg_cnt_q - 1;
      end
    end
  end

  // The stopped, alarm and code levels come straight from the bench controls.
  assign engine = '{foreground_complete_flag: foreground_complete_flag_q, bg_stopped: stop_req, bg_pass_done: pass_done_q,
                    alarm: alarm_in, code: code_in};
endmodule

// ==== tb/adc_calibration_control_regs_tb_top.sv ====
// Self-checking bench for the calibration control register bank.
// Assumes the bank is built with a low-power time unit of one clock cycle.
`timescale 1ns/1ps
module adc_calibration_control_regs_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  cal_ctrl_pkg::reg_req_type     req = '0;
  cal_ctrl_pkg::engine_stat_type engine;
  logic [7:0] reg_rdata_q, d0, d1;
  logic [2:0] offset_averaging_depth_q, code_in = 3'h0;
  logic cal_enable = 1'b0, foreground_run_select = 1'b1, background_recal_enable = 1'b0;
  logic hardware_trigger_pin = 1'b0, calibration_status_pin_q, clear_values_q, fg_start_q;
  logic bg_run_q, adc_sleep_q, cal_trigger_q;
  logic stop_req = 1'b0, pass_req = 1'b0, alarm_in = 1'b0;
  int   error_cnt = 0, comparisons = 0, fg_starts = 0, n;

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  cal_ctrl_regs #(.lp_unit(1)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_req(req),
    .reg_rdata_q(reg_rdata_q), .cal_enable(cal_enable),
    .foreground_run_select(foreground_run_select),
    .background_recal_enable(background_recal_enable),
    .hardware_trigger_pin(hardware_trigger_pin),
    .calibration_status_pin_q(calibration_status_pin_q), .engine(engine),
    .clear_values_q(clear_values_q), .fg_start_q(fg_start_q), .bg_run_q(bg_run_q),
    .adc_sleep_q(adc_sleep_q), .cal_trigger_q(cal_trigger_q),
    .offset_averaging_depth_q(offset_averaging_depth_q));

  cal_engine_model eng (.clk_sys(clk_sys), .reset_n(reset_n), .fg_start_q(fg_start_q),
    .bg_run_q(bg_run_q), .stop_req(stop_req), .pass_req(pass_req), .alarm_in(alarm_in),
    .code_in(code_in), .engine(engine));

  // Counts foreground start pulses so a skipped run can be seen.
  always @(posedge clk_sys) begin
    if (fg_start_q === 1'b1) fg_starts++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers; all stimulus moves on the falling edge.
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge clk_sys);
    req.rd = 1'b0;
    @(negedge clk_sys);
    d = reg_rdata_q;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, e, "register read");
  endtask
  // Reconfigures while disabled, then restarts and checks the clear-start pair.
  task automatic restart(input logic fg, input logic bg);
    int i;
    cal_enable              = 1'b0;
    foreground_run_select   = fg;
    background_recal_enable = bg;
    cyc(2);
    cal_enable = 1'b1;
    for (i = 0; i < 4 && clear_values_q !== 1'b1; i++) cyc(1);
    chk({7'h00, clear_values_q}, 8'h01, "clear pulse missing");
    cyc(1);
    chk({6'h00, clear_values_q, fg_start_q}, {7'h00, fg}, "start after clear");
  endtask
  task automatic wait_run();
    for (n = 0; n < 40 && bg_run_q !== 1'b1; n++) cyc(1);
    chk({7'h00, bg_run_q}, 8'h01, "background not running");
  endtask
  task automatic pass_sleep();
    pass_req = 1'b1;
    cyc(1);
    pass_req = 1'b0;
    for (n = 0; n < 4 && adc_sleep_q !== 1'b1; n++) cyc(1);
    chk({7'h00, adc_sleep_q}, 8'h01, "no sleep after pass");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    rdchk(8'h68, 8'hff, 8'h61);
    rdchk(8'h6b, 8'hff, 8'h00);
    rdchk(8'h6c, 8'hff, 8'h01);
    rdchk(8'h6e, 8'hff, 8'h88);
    rdchk(8'h55, 8'hff, 8'h00);
    chk({5'h00, offset_averaging_depth_q}, 8'h06, "depth reset");
    chk({7'h00, cal_trigger_q}, 8'h01, "soft trigger reset");
    $display("test reset values done");
  endtask
  task automatic t_regs();
    wr(8'h68, 8'hff);
    rdchk(8'h68, 8'hff, 8'hf1);
    chk({5'h00, offset_averaging_depth_q}, 8'h07, "depth max");
    wr(8'h68, 8'h05);
    // The depth output is a registered copy of the field, one edge behind it.
    cyc(1);
    chk({5'h00, offset_averaging_depth_q}, 8'h00, "depth min");
    wr(8'h68, 8'h61);
    rd(8'h6a, d0);
    wr(8'h6a, ~d0);
    rd(8'h6a, d1);
    chk(d1, d0, "status register written");
    wr(8'h6e, 8'h7b);
    rdchk(8'h6e, 8'hff, 8'h7b);
    wr(8'h69, 8'hff);
    rdchk(8'h69, 8'hff, 8'h00);
    $display("test register access done");
  endtask
  task automatic t_fg();
    code_in = 3'h5;
    restart(1'b1, 1'b0);
    rdchk(8'h6a, 8'h03, 8'h00);
    cyc(10);
    rdchk(8'h6a, 8'h1f, 8'h17);
    n = fg_starts;
    code_in = 3'h2;
    restart(1'b0, 1'b0);
    cyc(2);
    rdchk(8'h6a, 8'h1f, 8'h0b);
    chk(8'(fg_starts - n), 8'h00, "skipped run started");
    $display("test foreground done");
  endtask
  task automatic t_pin();
    logic [3:0] exp = 4'b0101;
    restart(1'b0, 1'b1);
    wait_run();
    alarm_in = 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(8'h6b, {5'h00, 2'(s), 1'b0});
      cyc(2);
      chk({7'h00, calibration_status_pin_q}, {7'h00, exp[s]}, "status pin");
    end
    alarm_in = 1'b0;
    wr(8'h6b, 8'h04);
    cyc(2);
    chk({7'h00, calibration_status_pin_q}, 8'h00, "alarm pin low");
    stop_req = 1'b1;
    wr(8'h6b, 8'h02);
    cyc(2);
    chk({7'h00, calibration_status_pin_q}, 8'h01, "stopped pin");
    rdchk(8'h6a, 8'h02, 8'h02);
    stop_req = 1'b0;
    cyc(2);
    rdchk(8'h6a, 8'h02, 8'h00);
    wr(8'h6b, 8'h00);
    $display("test status pin done");
  endtask
  task automatic t_trig();
    wr(8'h6c, 8'h00);
    hardware_trigger_pin = 1'b1;
    cyc(6);
    chk({7'h00, cal_trigger_q}, 8'h00, "pin not ignored");
    wr(8'h6c, 8'h01);
    hardware_trigger_pin = 1'b0;
    cyc(6);
    chk({7'h00, cal_trigger_q}, 8'h01, "soft trigger");
    wr(8'h6b, 8'h01);
    cyc(6);
    chk({7'h00, cal_trigger_q}, 8'h00, "hardware low");
    hardware_trigger_pin = 1'b1;
    wr(8'h6c, 8'h00);
    cyc(6);
    chk({7'h00, cal_trigger_q}, 8'h01, "hardware high");
    wr(8'h6b, 8'h00);
    wr(8'h6c, 8'h01);
    hardware_trigger_pin = 1'b0;
    $display("test trigger source done");
  endtask
  task automatic t_lp();
    cal_enable = 1'b0;
    wr(8'h6e, 8'h01);
    restart(1'b0, 1'b1);
    wait_run();
    pass_sleep();
    for (n = 0; n < 60 && adc_sleep_q === 1'b1; n++) cyc(1);
    chk({7'h00, n >= 8 && n <= 12}, 8'h01, "sleep length");
    wait_run();
    cal_enable = 1'b0;
    wr(8'h6e, 8'h03);
    restart(1'b0, 1'b1);
    wait_run();
    pass_sleep();
    cyc(40);
    chk({7'h00, adc_sleep_q}, 8'h01, "woke with trigger high");
    wr(8'h6c, 8'h00);
    for (n = 0; n < 10 && adc_sleep_q === 1'b1; n++) cyc(1);
    chk({7'h00, adc_sleep_q}, 8'h00, "no wake on low trigger");
    wr(8'h6c, 8'h01);
    restart(1'b0, 1'b0);
    pass_req = 1'b1;
    cyc(1);
    pass_req = 1'b0;
    cyc(10);
    chk({6'h00, bg_run_q, adc_sleep_q}, 8'h00, "low power without background");
    cal_enable = 1'b0;
    wr(8'h6e, 8'h88);
    $display("test low power done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The tests take a few hundred cycles; the 20000-cycle limit marks a hang.
  initial begin
    #200000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    cyc(1);
    t_reset();
    t_regs();
    t_fg();
    t_pin();
    t_trig();
    t_lp();
    wrap_up();
  end
endmodule
